// *** core/eeiv_consts.svh ***
// constants for the extra external interrupt and vector block
`ifndef EEIV_CONSTS_SVH
`define EEIV_CONSTS_SVH
// ************************************************************
// register addresses
// ************************************************************
`define EEIV_XCTL_ADDR 8'hc0
`define EEIV_PORT_ADDR 8'hd8
// bit address of bit 0 of each bit-addressable register
`define EEIV_XCTL_BIT0 8'hc0
`define EEIV_PORT_BIT0 8'hd8
// ************************************************************
// field positions in extra_irq_control
// ************************************************************
`define EEIV_IT2_POS 0
`define EEIV_IE2_POS 1
`define EEIV_EX2_POS 2
`define EEIV_PX2_POS 3
`define EEIV_IT3_POS 4
`define EEIV_IE3_POS 5
`define EEIV_EX3_POS 6
`define EEIV_PX3_POS 7
// ************************************************************
// reset values and vector layout
// ************************************************************
`define EEIV_XCTL_RST 8'h00
`define EEIV_PORT_RST 4'hf
`define EEIV_VEC_LOW 3'h3
`define EEIV_STD_GLOBAL_POS 7
`define EEIV_SRC_IRQ2 3'h6
`define EEIV_SRC_IRQ3 3'h7
`endif

// *** core/eeiv_pkg.sv ***
// types shared by the extra external interrupt block
package eeiv_pkg;
	typedef logic [2:0] eeiv_src_type;
	typedef enum logic {EEIV_IDLE, EEIV_PENDING} eeiv_req_state_type;
endpackage

// *** core/eeiv_pin_sense.sv ***
// pin synchroniser and falling-edge / low-level sensing for one interrupt pin
`timescale 1ns/1ps
`default_nettype none
module eeiv_pin_sense
	import eeiv_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic pin_i, // raw pin level
	output logic pin_sync, // synchronised level
	output logic fall_pulse, // one cycle on a falling edge
	output logic low_level // pin sampled low
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;

	always_comb begin
		sh_d = sh_q;
		if (ce) begin
			sh_d = {sh_q[1:0], pin_i};
		end
	end

	// pins idle high, so reset to high to avoid a false edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sh_q <= 3'h7;
		end else begin
			sh_q <= sh_d;
		end
	end

	// stage 0 is read only by stage 1
	assign pin_sync = sh_q[1];
	assign fall_pulse = ce & sh_q[2] & ~sh_q[1];
	assign low_level = ~sh_q[1];
endmodule // eeiv_pin_sense
`default_nettype wire

// *** core/eeiv_irq_top.sv ***
// extra external interrupts, auxiliary nibble port and two-level vector arbiter
`timescale 1ns/1ps
`default_nettype none
`include "eeiv_consts.svh"
// Behaviour
// - extra_irq_control sits at special function address 0C0H and is bit-addressable.
// - a bit set at bit address 0C2H sets irq2_allow, bits mapped upward from 0C0H.
// - a set priority bit makes interrupt 2 or 3 high priority, a clear one low priority.
// - interrupt 2 or 3 reaches the core only while its allow bit is one.
// - edge select one senses falling edges, zero senses a low level.
// - in edge mode the flag is set by an edge and cleared when the core vectors to it.
// - vectors are 03H upward in steps of eight bytes, 33H and 3BH for interrupts 2 and 3.
// - equal-level requests are granted in polling order 0 to 7.
// - irq2_allow is bit 2, irq2_edge_select bit 0, irq3_allow bit 6.
// - the six standard sources are allowed by bits 0 to 5 of the standard allow register.
// - the auxiliary port sits at 0D8H, bit-addressable, with only four low bits usable.
// - port bits 2 and 3 also serve as interrupt pins while remaining general pins.
// - each port pin is quasi-bidirectional with a pull-up, as the first general port.
module eeiv_irq_top
	import eeiv_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic [7:0] sfr_addr, // byte address for sfr access
	input wire logic [7:0] sfr_wdata, // byte write data
	input wire logic sfr_wr, // byte write strobe
	input wire logic sfr_rd, // byte read strobe
	input wire logic [7:0] bit_addr, // bit address for bit access
	input wire logic bit_val, // value for bit write
	input wire logic bit_wr, // bit write strobe
	output logic [7:0] sfr_rdata, // read data, one cycle after sfr_rd
	input wire logic [7:0] std_irq_allow_reg, // standard allow bits, bit 7 global
	input wire logic [5:0] std_prio, // high-priority bits of standard sources
	input wire logic [5:0] std_req, // standard source request flags
	input wire logic irq_ack, // core vectors to irq_vector
	input wire logic irq_reti, // core returns from a routine
	output logic irq_req, // request to core
	output logic [7:0] irq_vector, // vector address
	output logic [2:0] irq_src, // polling index of request
	input wire logic [3:0] aux_pin_i, // aux port pin levels
	output logic [3:0] aux_pin_o, // aux port pin drive value
	output logic [3:0] aux_pin_oe_n // low while pin is driven
);
	// ************************************************************
	// pin sensing
	// ************************************************************
	logic [3:0] pin_sync;
	logic [3:0] fall;
	logic [3:0] low;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			eeiv_pin_sense u_sense (
				.mclk(mclk),
				.resetn(resetn),
				.ce(ce),
				.pin_i(aux_pin_i[g]),
				.pin_sync(pin_sync[g]),
				.fall_pulse(fall[g]),
				.low_level(low[g])
			);
		end
	endgenerate

	function automatic logic [2:0] first_set(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] xctl_q, xctl_d;
	logic [3:0] port_q, port_d;
	logic [7:0] rdata_q, rdata_d;
	logic [3:0] oe_n_q, oe_n_d;
	logic [3:0] pout_q, pout_d;
	logic [7:0] wr_x, wr_p;
	logic [7:0] wr_xv, wr_pv;

	always_comb begin
		wr_x = 8'h00;
		wr_p = 8'h00;
		wr_xv = sfr_wdata;
		wr_pv = sfr_wdata;
		if (sfr_wr && sfr_addr == `EEIV_XCTL_ADDR) begin
			wr_x = 8'hff;
		end else if (sfr_wr && sfr_addr == `EEIV_PORT_ADDR) begin
			wr_p = 8'h0f;
		end else if (bit_wr && bit_addr[7:3] == 5'(`EEIV_XCTL_BIT0 >> 3)) begin
			wr_x[bit_addr[2:0]] = 1'b1;
			wr_xv = {8{bit_val}};
		end else if (bit_wr && bit_addr[7:3] == 5'(`EEIV_PORT_BIT0 >> 3)) begin
			wr_p[bit_addr[2:0]] = 1'b1;
			wr_pv = {8{bit_val}};
		end
	end

	// arbiter state read by the flag clear, so declared ahead of it
	logic irq_req_q, irq_req_d;
	eeiv_src_type src_q, src_d;
	logic ack_hit2, ack_hit3;
	assign ack_hit2 = irq_ack && irq_req_q && src_q == `EEIV_SRC_IRQ2;
	assign ack_hit3 = irq_ack && irq_req_q && src_q == `EEIV_SRC_IRQ3;

	always_comb begin
		xctl_d = xctl_q;
		port_d = port_q;
		rdata_d = rdata_q;
		oe_n_d = oe_n_q;
		pout_d = pout_q;
		if (ce) begin
			xctl_d = (xctl_q & ~wr_x) | (wr_xv & wr_x);
			port_d = (port_q & ~wr_p[3:0]) | (wr_pv[3:0] & wr_p[3:0]);
			// vectoring clears, an edge in the same cycle wins
			if (ack_hit2) begin
				xctl_d[`EEIV_IE2_POS] = 1'b0;
			end
			if (ack_hit3) begin
				xctl_d[`EEIV_IE3_POS] = 1'b0;
			end
			// edge select picks the sensing mode
			// pin 2 to irq 2, pin 3 to irq 3
			if (xctl_q[`EEIV_IT2_POS]) begin
				if (fall[2]) begin
					xctl_d[`EEIV_IE2_POS] = 1'b1;
				end
			end else begin
				xctl_d[`EEIV_IE2_POS] = low[2];
			end
			if (xctl_q[`EEIV_IT3_POS]) begin
				if (fall[3]) begin
					xctl_d[`EEIV_IE3_POS] = 1'b1;
				end
			end else begin
				xctl_d[`EEIV_IE3_POS] = low[3];
			end
			if (sfr_rd && sfr_addr == `EEIV_XCTL_ADDR) begin
				rdata_d = xctl_q;
			end else if (sfr_rd && sfr_addr == `EEIV_PORT_ADDR) begin
				// pins read back as plain inputs too
				rdata_d = {4'h0, pin_sync};
			end else if (sfr_rd) begin
				rdata_d = 8'h00;
			end
			// drive low for a zero, release to the pull-up for a one
			pout_d = port_d;
			oe_n_d = port_d;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			xctl_q <= `EEIV_XCTL_RST;
			port_q <= `EEIV_PORT_RST;
			rdata_q <= 8'h00;
			oe_n_q <= `EEIV_PORT_RST;
			pout_q <= `EEIV_PORT_RST;
		end else begin
			xctl_q <= xctl_d;
			port_q <= port_d;
			rdata_q <= rdata_d;
			oe_n_q <= oe_n_d;
			pout_q <= pout_d;
		end
	end

	// ************************************************************
	// arbiter
	// ************************************************************
	logic [7:0] pend, hi;
	logic [7:0] pend_hi, pend_lo;
	logic act_hi_q, act_hi_d, act_lo_q, act_lo_d;
	logic [7:0] vec_q, vec_d;
	logic hi_q, hi_d;

	always_comb begin
		pend[5:0] = std_req & std_irq_allow_reg[5:0];
		pend[6] = xctl_q[`EEIV_IE2_POS] & xctl_q[`EEIV_EX2_POS];
		pend[7] = xctl_q[`EEIV_IE3_POS] & xctl_q[`EEIV_EX3_POS];
		pend = pend & {8{std_irq_allow_reg[`EEIV_STD_GLOBAL_POS]}};
		hi = {xctl_q[`EEIV_PX3_POS], xctl_q[`EEIV_PX2_POS], std_prio};
		pend_hi = pend & hi;
		pend_lo = pend & ~hi;
	end

	always_comb begin
		act_hi_d = act_hi_q;
		act_lo_d = act_lo_q;
		irq_req_d = irq_req_q;
		src_d = src_q;
		vec_d = vec_q;
		hi_d = hi_q;
		if (ce) begin
			if (irq_ack && irq_req_q) begin
				if (hi_q) begin
					act_hi_d = 1'b1;
				end else begin
					act_lo_d = 1'b1;
				end
			end else if (irq_reti) begin
				if (act_hi_q) begin
					act_hi_d = 1'b0;
				end else begin
					act_lo_d = 1'b0;
				end
			end
			irq_req_d = 1'b0;
			// only a higher level may interrupt
			if (pend_hi != 8'h00 && !act_hi_d) begin
				irq_req_d = 1'b1;
				src_d = first_set(pend_hi);
				hi_d = 1'b1;
			end else if (pend_lo != 8'h00 && !act_hi_d && !act_lo_d) begin
				irq_req_d = 1'b1;
				src_d = first_set(pend_lo);
				hi_d = 1'b0;
			end
			// vector is index times eight plus three
			vec_d = {2'b00, src_d, `EEIV_VEC_LOW};
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			act_hi_q <= 1'b0;
			act_lo_q <= 1'b0;
			irq_req_q <= 1'b0;
			src_q <= 3'h0;
			vec_q <= 8'h03;
			hi_q <= 1'b0;
		end else begin
			act_hi_q <= act_hi_d;
			act_lo_q <= act_lo_d;
			irq_req_q <= irq_req_d;
			src_q <= src_d;
			vec_q <= vec_d;
			hi_q <= hi_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign irq_req = irq_req_q;
	assign irq_vector = vec_q;
	assign irq_src = src_q;
	assign aux_pin_o = pout_q;
	assign aux_pin_oe_n = oe_n_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	AST_VEC_MAP: assert property (irq_req |-> irq_vector == {2'b00, irq_src, 3'h3})
		else $error("vector does not match source");
	AST_ALLOW2: assert property (irq_req && irq_src == 3'h6 |-> $past(xctl_q[2]))
		else $error("irq2 granted while not allowed");
	AST_BIT_SET: assert property (ce && bit_wr && bit_addr == 8'hc2 && !sfr_wr
		|=> xctl_q[2])
		else $error("bit set at 0C2H missed");
	AST_BYTE_WR: assert property (ce && sfr_wr && sfr_addr == 8'hc0
		|=> xctl_q[7:6] == $past(sfr_wdata[7:6]))
		else $error("byte write at 0C0H lost");
	AST_EDGE_SET: assert property (ce && xctl_q[0] && fall[2] |=> xctl_q[1])
		else $error("edge did not set irq2 flag");
	AST_LEVEL: assert property (ce && !xctl_q[4] |=> xctl_q[5] == $past(low[3]))
		else $error("level flag does not follow pin");
	AST_NO_PREEMPT: assert property (act_hi_q && ce && !irq_reti |=> !irq_req)
		else $error("request during high-level routine");
	AST_ORDER: assert property (irq_req && !hi_q |-> $past(pend_lo & ~hi) == 8'h00
		|| (($past(pend_lo) & ((8'h01 << irq_src) - 8'h01)) == 8'h00))
		else $error("polling order broken");
	AST_PORT_DRIVE: assert property (ce && sfr_wr && sfr_addr == 8'hd8
		|=> aux_pin_oe_n == $past(sfr_wdata[3:0]))
		else $error("port drive does not follow latch");
	AST_HI_LEVEL: assert property (irq_req && irq_src == 3'h7 |-> hi_q == $past(xctl_q[7]))
		else $error("irq3 level wrong");

	COV_IRQ2: cover property (irq_req && irq_src == 3'h6 ##1 irq_ack);
	COV_IRQ3_HI: cover property (irq_req && irq_src == 3'h7 && hi_q);
	COV_PREEMPT: cover property (act_lo_q && irq_req && hi_q);
endmodule // eeiv_irq_top
`default_nettype wire

// *** verif/eeiv_pin_model.sv ***
// outside devices and pull-ups on the auxiliary nibble pins
`timescale 1ns/1ps
`default_nettype none
module eeiv_pin_model (
	input wire logic [3:0] pin_o, // device drive value
	input wire logic [3:0] pin_oe_n, // low while the device drives
	input wire logic [3:0] ext_low, // outside device pulls the pin low
	output logic [3:0] pin_lvl // resolved pin level
);
	// ********************
	// wire resolution
	// ********************
	// shared pins, pull-up
	// a released pin rises to the pull-up and never keeps the last value
	assign pin_lvl = ~ext_low & (pin_oe_n | pin_o);
endmodule // eeiv_pin_model
`default_nettype wire

// *** verif/extra_ext_irq_and_vectors_tb.sv ***
// self-checking bench for the extra interrupts, vectors and nibble port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module extra_ext_irq_and_vectors_tb;
	logic mclk, resetn, sfr_wr, sfr_rd, bit_val, bit_wr, irq_ack, irq_reti, irq_req;
	logic ce;
	logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, std_allow, irq_vector;
	logic [5:0] std_prio, std_req;
	logic [2:0] irq_src;
	logic [3:0] pin_lvl, pin_o, pin_oe_n, ext_low;
	int err_count, num_checks;
	eeiv_irq_top dut_u (.mclk(mclk), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .bit_addr(bit_addr),
		.bit_val(bit_val), .bit_wr(bit_wr), .sfr_rdata(sfr_rdata), .std_irq_allow_reg(std_allow),
		.std_prio(std_prio), .std_req(std_req), .irq_ack(irq_ack), .irq_reti(irq_reti),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_src(irq_src), .aux_pin_i(pin_lvl),
		.aux_pin_o(pin_o), .aux_pin_oe_n(pin_oe_n));
	eeiv_pin_model pin_u (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_low(ext_low),
		.pin_lvl(pin_lvl));
	// ********************
	// access tasks
	// ********************
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
		tick(1);
	endtask
	task automatic bw(input logic [7:0] a, input logic v);
		bit_addr = a;
		bit_val = v;
		bit_wr = 1'b1;
		tick(1);
		bit_wr = 1'b0;
		tick(1);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		sfr_rd = 1'b1;
		tick(1);
		sfr_rd = 1'b0;
		`CHK(sfr_rdata, e)
		tick(1);
	endtask
	// r low acknowledges a vector, r high returns from the routine
	task automatic done(input logic r);
		irq_ack = ~r;
		irq_reti = r;
		tick(1);
		{irq_ack, irq_reti} = 2'b00;
		tick(1);
	endtask
	task automatic wreq(input logic e, input logic [7:0] v, input logic [2:0] s);
		int i;
		// a request may already stand for another source, so wait for the wanted one
		for (i = 0; i < 20 && !(irq_req === e && (!e || irq_src === s)); i++) tick(1);
		`CHK(irq_req, e)
		if (irq_req !== e) stop_test();
		if (e) begin
			`CHK(irq_vector, v)
			`CHK(irq_src, s)
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ********************
	// clock and sequence
	// ********************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		{sfr_wr, sfr_rd, bit_wr, bit_val, irq_ack, irq_reti} = 6'h00;
		{sfr_addr, sfr_wdata, bit_addr, std_allow} = 32'h0000_0000;
		{std_prio, std_req, ext_low} = 16'h0000;
		ce = 1'b1;
		err_count = 0;
		num_checks = 0;
		resetn = 1'b0;
		repeat (8) @(posedge mclk);
		#1 resetn = 1'b1;
		tick(2);
		rdc(8'hc0, 8'h00);
		rdc(8'hd8, 8'h0f);
		rdc(8'h55, 8'h00);
		wr(8'hd8, 8'ha5);
		// pin reads pass the two-stage synchroniser first
		tick(2);
		rdc(8'hd8, 8'h05);
		`CHK(pin_oe_n, 4'h5)
		`CHK(pin_o, 4'h5)
		bw(8'hdb, 1'b1);
		tick(2);
		rdc(8'hd8, 8'h0d);
		wr(8'hd8, 8'hff);
		tick(4);
		rdc(8'hd8, 8'h0f);
		bw(8'hc2, 1'b1);
		rdc(8'hc0, 8'h04);
		bw(8'hc6, 1'b1);
		bw(8'hc0, 1'b1);
		rdc(8'hc0, 8'h45);
		// edge mode: one edge, one service, no repeat while the pin stays low
		std_allow = 8'h80;
		wr(8'hc0, 8'h05);
		ext_low = 4'h4;
		wreq(1'b1, 8'h33, 3'h6);
		rdc(8'hc0, 8'h07);
		done(1'b0);
		tick(1);
		rdc(8'hc0, 8'h05);
		done(1'b1);
		tick(3);
		`CHK(irq_req, 1'b0)
		// level mode on both pins
		wr(8'hc0, 8'h00);
		ext_low = 4'hc;
		tick(10);
		`CHK(irq_req, 1'b0)
		wr(8'hc0, 8'h44);
		wreq(1'b1, 8'h33, 3'h6);
		rdc(8'hc0, 8'h66);
		ext_low = 4'h8;
		wreq(1'b1, 8'h3b, 3'h7);
		ext_low = 4'h0;
		wreq(1'b0, 8'h00, 3'h0);
		wr(8'hc0, 8'h00);
		// standard sources, each allowed alone, then 4 and 5 with all six allowed
		std_req = 6'h3f;
		for (int i = 0; i < 6; i++) begin
			std_allow = 8'h80 | (8'h01 << i);
			wreq(1'b1, 8'(i * 8 + 3), 3'(i));
		end
		std_allow = 8'hbf;
		std_req = 6'h30;
		wreq(1'b1, 8'h23, 3'h4);
		// low routine running: only a high-priority source gets through
		std_allow = 8'h81;
		std_req = 6'h01;
		wreq(1'b1, 8'h03, 3'h0);
		done(1'b0);
		tick(3);
		`CHK(irq_req, 1'b0)
		wr(8'hc0, 8'h0c);
		ext_low = 4'h4;
		wreq(1'b1, 8'h33, 3'h6);
		// high routine running: nothing at all gets through
		done(1'b0);
		tick(3);
		`CHK(irq_req, 1'b0)
		done(1'b1);
		wreq(1'b1, 8'h33, 3'h6);
		wr(8'hc0, 8'h04);
		wreq(1'b0, 8'h00, 3'h0);
		std_req = 6'h00;
		ext_low = 4'h0;
		done(1'b1);
		tick(4);
		// clock enable low: a byte write must not land
		ce = 1'b0;
		wr(8'hc0, 8'h80);
		ce = 1'b1;
		rdc(8'hc0, 8'h04);
		stop_test();
	end
endmodule // extra_ext_irq_and_vectors_tb
`default_nettype wire
